// ### src/mmc_pkg.sv
/*
  Package of the monitor menu control: map, fields, codes, timing.
  Assumes one 40 MHz system clock.
*/
package mmc_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000; // System clock rate
  localparam int unsigned GESTURE_WIN_S = 5;          // Corner gesture window
  localparam int unsigned MENU_IDLE_S   = 30;         // Menu inactivity limit
  localparam int unsigned DEBOUNCE_MS   = 10;         // Switch settle time
  localparam int unsigned BLINK_MS      = 500;        // Lamp half period
  localparam int unsigned GESTURE_CYC   = GESTURE_WIN_S * CLK_HZ;
  localparam int unsigned MENU_IDLE_CYC = MENU_IDLE_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CMD      = 8'h00; // W: menu command
  localparam logic [7:0] REG_STATUS   = 8'h04; // R: block state
  localparam logic [7:0] REG_VAL0     = 8'h08; // R: picture values
  localparam logic [7:0] REG_VAL1     = 8'h0c; // R: other values
  localparam logic [7:0] REG_IRQ_STAT = 8'h10; // R/W1C: sticky events
  localparam logic [7:0] REG_IRQ_MASK = 8'h14; // R/W: event mask

  // Command register fields
  localparam int CMD_CODE_LSB = 0;  // Command code, 4 bits
  localparam int CMD_ITEM_LSB = 8;  // Item number, 4 bits

  // Status register fields
  localparam int ST_MENU_BIT    = 0;  // Menu active
  localparam int ST_STATE_LSB   = 1;  // Menu state, 3 bits
  localparam int ST_USB_BIT     = 4;  // Touch link on USB
  localparam int ST_HIDE_BIT    = 5;  // Menu hidden
  localparam int ST_DIGITAL_BIT = 6;  // Digital video selected
  localparam int ST_NOSETUP_BIT = 7;  // No-setup message shown
  localparam int ST_GSTEP_LSB   = 8;  // Gesture progress, 2 bits
  localparam int ST_ITEM_LSB    = 12; // Open item, 4 bits
  localparam int ST_PEND_LSB    = 16; // Pending value, 8 bits

  // Interrupt event bits
  localparam int IRQ_W        = 5;
  localparam int EV_ENTER     = 0; // Menu opened
  localparam int EV_EXIT      = 1; // Menu closed by cancel command
  localparam int EV_TIMEOUT   = 2; // Menu closed by inactivity
  localparam int EV_SAVE      = 3; // Save requested
  localparam int EV_AUTO_DONE = 4; // Auto level adjust finished
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

  // ------------------------------------------------------------------
  // Commands, items, corners
  // ------------------------------------------------------------------
  localparam logic [3:0] CMD_OPEN   = 4'h1; // Open item from top menu
  localparam logic [3:0] CMD_UP     = 4'h2; // Increase pending value
  localparam logic [3:0] CMD_DOWN   = 4'h3; // Decrease pending value
  localparam logic [3:0] CMD_SET    = 4'h4; // Apply pending value
  localparam logic [3:0] CMD_CANCEL = 4'h5; // Cancel button
  localparam logic [3:0] CMD_START  = 4'h6; // Start action item
  localparam logic [3:0] CMD_SAVE   = 4'h7; // Save and quit

  localparam int NUM_ITEMS = 11;
  localparam logic [3:0] IT_CONTRAST = 4'h0;
  localparam logic [3:0] IT_BLACK    = 4'h1;
  localparam logic [3:0] IT_HPOS     = 4'h2;
  localparam logic [3:0] IT_VPOS     = 4'h3;
  localparam logic [3:0] IT_HSIZE    = 4'h4; // horizontal_size_item
  localparam logic [3:0] IT_PHASE    = 4'h5;
  localparam logic [3:0] IT_LAMP     = 4'h6; // lamp_brightness_item
  localparam logic [3:0] IT_AUTO     = 4'h7; // auto_level_adjust
  localparam logic [3:0] IT_CLEAR    = 4'h8;
  localparam logic [3:0] IT_CLICK    = 4'h9; // 0 off, 1..7 level
  localparam logic [3:0] IT_TEXT     = 4'ha; // Text-mode resolution

  localparam logic [7:0] MAX_BYTE  = 8'hff; // Full-range items
  localparam logic [7:0] MAX_PHASE = 8'h1f; // 32 steps
  localparam logic [7:0] MAX_LAMP  = 8'h08; // 9 levels
  localparam logic [7:0] MAX_CLICK = 8'h07;
  localparam logic [7:0] MAX_TEXT  = 8'h01;
  localparam logic [7:0] DEF_MID   = 8'h80; // Picture default
  localparam logic [7:0] DEF_PHASE = 8'h10;
  localparam logic [7:0] DEF_LAMP  = 8'h08;
  localparam logic [7:0] DEF_OFF   = 8'h00; // Click and text mode off

  localparam logic [1:0] CORNER_NONE = 2'h0;
  localparam logic [1:0] CORNER_UL   = 2'h1;
  localparam logic [1:0] CORNER_UR   = 2'h2;
  localparam logic [1:0] CORNER_LR   = 2'h3;

  typedef enum logic [2:0] {MS_OFF, MS_TOP, MS_SET, MS_MSG, MS_AUTO}
    mmc_menu_t;

endpackage : mmc_pkg

// ### src/mmc_top.sv
/*
  Monitor menu control: switches, lamp, corner gesture, menu, APB, irq.
  Assumes inputs synchronous to SYS_CLK_I except the debounced switches.
*/
// The APB slave port and the address map were decided locally.
// Functional notes
// - Switch off serial touch link, on USB
// - Menu-hide switch on suppresses menu entirely
// - Video switch on digital, off analog
// - Lamp colour from power, backlight, image
// - Three-corner gesture within five seconds opens menu
// - No touch forwarding while menu active
// - Leave menu on cancel or idle
// - Idle timeout keeps values being edited
// - Set applies value, save stores persistently
// - Phase adjust 32 steps, analog only
// - Backlight brightness nine levels
// - Digital input: analog items show message
// - Menu clear restores all defaults
// - Cancel discards pending, closes at top
// - Auto adjust runs then returns to top
// - Click sound with level, default off
// - Text-mode resolution option, default off
`timescale 1ns/1ps
`default_nettype none
module mmc_top
  import mmc_pkg::*;
#(
  parameter int unsigned GESTURE_CYCLES  = GESTURE_CYC,
  parameter int unsigned IDLE_CYCLES     = MENU_IDLE_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned BLINK_CYCLES    = BLINK_CYC
)(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic             PREADY_O,
  output logic      [31:0] PRDATA_O,
  output logic             PSLVERR_O,
  output logic             IRQ_O,
  // Setup switches, raw
  input  wire logic        TOUCH_LINK_SELECT_SWITCH_I,
  input  wire logic        MENU_HIDE_SWITCH_I,
  input  wire logic        VIDEO_INPUT_SELECT_SWITCH_I,
  // Panel state
  input  wire logic        POWER_ON_I,
  input  wire logic        BACKLIGHT_BURNT_I,
  input  wire logic        IMAGE_PRESENT_I,
  // Touch events and auto adjust handshake
  input  wire logic        TOUCH_VALID_I,
  input  wire logic [1:0]  TOUCH_CORNER_I,
  input  wire logic        AUTO_DONE_I,
  // Routing and state
  output logic             LINK_USB_O,
  output logic             VIDEO_DIGITAL_O,
  output logic             TOUCH_SERIAL_VALID_O,
  output logic             TOUCH_USB_VALID_O,
  output logic             MENU_ACTIVE_O,
  output logic             NOSETUP_MSG_O,
  output logic             AUTO_START_O,
  output logic             SAVE_REQ_O,
  output logic             LAMP_GREEN_O,
  output logic             LAMP_RED_O,
  // Values in effect
  output logic      [7:0]  CONTRAST_O,
  output logic      [7:0]  BLACK_LEVEL_O,
  output logic      [7:0]  HPOS_O,
  output logic      [7:0]  VPOS_O,
  output logic      [7:0]  HSIZE_O,
  output logic      [4:0]  PHASE_O,
  output logic      [3:0]  BACKLIGHT_O,
  output logic             CLICK_EN_O,
  output logic      [2:0]  CLICK_LEVEL_O,
  output logic             TEXT_MODE_O
);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  if (GESTURE_CYCLES < 2 || IDLE_CYCLES < 2 || BLINK_CYCLES < 2)
    $error("mmc_top: counts below 2");
  if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 32'h00ff_ffff)
    $error("mmc_top: bad debounce");

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]            sw_s1;     // Synchroniser first stage
    logic [2:0]            sw_s2;     // Synchroniser second stage
    logic [2:0]            sw_db;     // Debounced switches
    logic [2:0][23:0]      db_cnt;    // Per-switch settle counters
    logic [31:0]           blink_div; // Lamp flash divider
    logic                  blink;     // Flash phase
    logic                  lamp_g;    // Lamp green element
    logic                  lamp_r;    // Lamp red element
    logic [1:0]            gstep;     // Corners seen so far
    logic [31:0]           gtmr;      // Gesture window timer
    mmc_menu_t             menu;      // Menu state
    logic [31:0]           idle;      // Inactivity timer
    logic [3:0]            item;      // Item being edited
    logic [7:0]            pend;      // Pending value
    logic [NUM_ITEMS-1:0][7:0] vals;  // Values in effect
    logic                  nosetup;   // Message flag
    logic                  auto_req;  // Auto adjust start pulse
    logic                  save_req;  // Save pulse
    logic [IRQ_W-1:0]      irq_st;    // Sticky events
    logic [IRQ_W-1:0]      irq_mk;    // Event mask
    logic [31:0]           prdata;    // Read data
    logic                  pslverr;   // Unmapped address
  } mmc_state_t;

  mmc_state_t q;  // Registered state
  mmc_state_t d;  // Next state

  // ------------------------------------------------------------------
  // Item helpers
  // ------------------------------------------------------------------
  // Upper bound of an item's value
  function automatic logic [7:0] item_max(input logic [3:0] it);
    unique case (it)
      IT_PHASE: item_max = MAX_PHASE;
      IT_LAMP:  item_max = MAX_LAMP;
      IT_CLICK: item_max = MAX_CLICK;
      IT_TEXT:  item_max = MAX_TEXT;
      default:  item_max = MAX_BYTE;
    endcase
  endfunction : item_max

  // Items that only mean something for analog video
  function automatic logic analog_only(input logic [3:0] it);
    analog_only = (it == IT_CONTRAST) || (it == IT_BLACK) ||
                  (it == IT_HSIZE) || (it == IT_PHASE) ||
                  (it == IT_AUTO);
  endfunction : analog_only

  // Factory value of every item
  function automatic logic [NUM_ITEMS-1:0][7:0] defaults();
    logic [NUM_ITEMS-1:0][7:0] v;
    v = '{default: DEF_MID};
    v[IT_PHASE] = DEF_PHASE;
    v[IT_LAMP]  = DEF_LAMP;
    v[IT_AUTO]  = DEF_OFF;
    v[IT_CLEAR] = DEF_OFF;
    v[IT_CLICK] = DEF_OFF;
    v[IT_TEXT]  = DEF_OFF;
    return v;
  endfunction : defaults

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  logic [2:0]       sw_raw;    // Raw switch levels
  logic             usb_sel;   // Debounced link select
  logic             hide;      // Debounced menu hide
  logic             digital;   // Debounced video select
  logic             acc;       // APB access phase
  logic             cmd_wr;    // Command written this cycle
  logic [3:0]       cmd;       // Command code
  logic [3:0]       cmd_it;    // Command item
  logic [IRQ_W-1:0] ev;        // Events this cycle
  logic [1:0]       step;      // Gesture step after expiry
  logic             activity;  // Touch or command in menu

  assign sw_raw  = {VIDEO_INPUT_SELECT_SWITCH_I, MENU_HIDE_SWITCH_I,
                    TOUCH_LINK_SELECT_SWITCH_I};
  assign usb_sel = q.sw_db[0];
  assign hide    = q.sw_db[1];
  assign digital = q.sw_db[2];
  assign acc     = PSEL_I && PENABLE_I;
  assign cmd_wr  = acc && PWRITE_I && (PADDR_I == REG_CMD);
  assign cmd     = PWDATA_I[CMD_CODE_LSB +: 4];
  assign cmd_it  = PWDATA_I[CMD_ITEM_LSB +: 4];

  always_comb
  begin
    d        = q;
    d.auto_req = 1'b0;
    d.save_req = 1'b0;
    ev       = '0;
    step     = q.gstep;
    activity = TOUCH_VALID_I || cmd_wr;

    // Synchronise and debounce: a change must hold the settle time
    d.sw_s1 = sw_raw;
    d.sw_s2 = q.sw_s1;
    for (int i = 0; i < 3; i++)
    begin
      if (q.sw_s2[i] == q.sw_db[i])
        d.db_cnt[i] = '0;
      else if (q.db_cnt[i] == 24'(DEBOUNCE_CYCLES - 1))
      begin
        d.sw_db[i]  = q.sw_s2[i];
        d.db_cnt[i] = '0;
      end
      else
        d.db_cnt[i] = q.db_cnt[i] + 24'h000001;
    end

    // Flash divider for the lamp
    if (q.blink_div == BLINK_CYCLES - 1)
    begin
      d.blink_div = '0;
      d.blink     = ~q.blink;
    end
    else
      d.blink_div = q.blink_div + 32'h0000_0001;

    // Lamp colour; orange lights both elements
    if (!POWER_ON_I)
    begin
      d.lamp_g = 1'b0;
      d.lamp_r = 1'b0;
    end
    else if (!BACKLIGHT_BURNT_I)
    begin
      d.lamp_g = 1'b1;
      d.lamp_r = !IMAGE_PRESENT_I;
    end
    else if (IMAGE_PRESENT_I)
    begin
      d.lamp_g = q.blink;
      d.lamp_r = !q.blink;
    end
    else
    begin
      d.lamp_g = q.blink;
      d.lamp_r = q.blink;
    end

    // APB setup phase: latch read data and error
    if (PSEL_I && !PENABLE_I)
    begin
      d.prdata  = '0;
      d.pslverr = 1'b0;
      unique case (PADDR_I)
        REG_CMD: ;   // Write only, reads zero
        REG_STATUS:
        begin
          d.prdata[ST_MENU_BIT]     = (q.menu != MS_OFF);
          d.prdata[ST_STATE_LSB +: 3] = q.menu;
          d.prdata[ST_USB_BIT]      = usb_sel;
          d.prdata[ST_HIDE_BIT]     = hide;
          d.prdata[ST_DIGITAL_BIT]  = digital;
          d.prdata[ST_NOSETUP_BIT]  = q.nosetup;
          d.prdata[ST_GSTEP_LSB +: 2] = q.gstep;
          d.prdata[ST_ITEM_LSB +: 4]  = q.item;
          d.prdata[ST_PEND_LSB +: 8]  = q.pend;
        end
        REG_VAL0:
          d.prdata = {q.vals[IT_VPOS], q.vals[IT_HPOS],
                      q.vals[IT_BLACK], q.vals[IT_CONTRAST]};
        REG_VAL1:
          d.prdata = {q.vals[IT_TEXT], q.vals[IT_CLICK],
                      q.vals[IT_LAMP], q.vals[IT_PHASE]};
        REG_IRQ_STAT: d.prdata[IRQ_W-1:0] = q.irq_st;
        REG_IRQ_MASK: d.prdata[IRQ_W-1:0] = q.irq_mk;
        default:      d.pslverr = 1'b1; // Unmapped address
      endcase
    end

    // APB writes take effect in the access phase
    if (acc && PWRITE_I)
    begin
      if (PADDR_I == REG_IRQ_STAT)
        d.irq_st = q.irq_st & ~PWDATA_I[IRQ_W-1:0];
      if (PADDR_I == REG_IRQ_MASK)
        d.irq_mk = PWDATA_I[IRQ_W-1:0];
    end

    // Corner gesture, only watched while the menu is closed
    if (q.menu == MS_OFF)
    begin
      if (q.gstep != 2'h0)
      begin
        if (q.gtmr == GESTURE_CYCLES - 1)
          step = 2'h0;
        else
          d.gtmr = q.gtmr + 32'h0000_0001;
      end
      d.gstep = step;
      if (TOUCH_VALID_I && TOUCH_CORNER_I != CORNER_NONE)
      begin
        if (TOUCH_CORNER_I == CORNER_UL)
        begin
          d.gstep = 2'h1;
          d.gtmr  = '0;
        end
        else if (step == 2'h1 && TOUCH_CORNER_I == CORNER_UR)
          d.gstep = 2'h2;
        else if (step == 2'h2 && TOUCH_CORNER_I == CORNER_LR)
        begin
          d.gstep = 2'h0;
          // Hidden menu: the gesture is used up with no effect
          if (!hide)
          begin
            d.menu = MS_TOP;
            d.idle = '0;
            ev[EV_ENTER] = 1'b1;
          end
        end
        else
          d.gstep = 2'h0;
      end
    end
    else
    begin
      d.gstep = 2'h0;
      d.gtmr  = '0;
      // Idle timer; auto adjust is excluded as it needs no touch
      if (activity || q.menu == MS_AUTO)
        d.idle = '0;
      else
        d.idle = q.idle + 32'h0000_0001;

      if (hide)
      begin
        d.menu    = MS_OFF;
        d.nosetup = 1'b0;
      end
      else if (!activity && q.menu != MS_AUTO &&
               q.idle == IDLE_CYCLES - 1)
      begin
        // Value being edited is kept, unlike a cancel
        if (q.menu == MS_SET && q.item != IT_AUTO &&
            q.item != IT_CLEAR)
          d.vals[q.item] = q.pend;
        d.menu    = MS_OFF;
        d.nosetup = 1'b0;
        ev[EV_TIMEOUT] = 1'b1;
      end
      else
      begin
        unique case (q.menu)
          MS_TOP:
            if (cmd_wr)
            begin
              if (cmd == CMD_OPEN && cmd_it < 4'(NUM_ITEMS))
              begin
                d.item = cmd_it;
                d.pend = q.vals[cmd_it];
                if (digital && analog_only(cmd_it))
                begin
                  d.menu    = MS_MSG;
                  d.nosetup = 1'b1;
                end
                else
                  d.menu = MS_SET;
              end
              else if (cmd == CMD_SAVE)
              begin
                d.save_req = 1'b1;
                d.menu     = MS_OFF;
                ev[EV_SAVE] = 1'b1;
              end
              else if (cmd == CMD_CANCEL)
              begin
                d.menu = MS_OFF;
                ev[EV_EXIT] = 1'b1;
              end
            end
          MS_SET:
            if (cmd_wr)
            begin
              if (cmd == CMD_UP && q.pend < item_max(q.item))
                d.pend = q.pend + 8'h01;
              else if (cmd == CMD_DOWN && q.pend != 8'h00)
                d.pend = q.pend - 8'h01;
              else if (cmd == CMD_SET && q.item != IT_AUTO &&
                       q.item != IT_CLEAR)
              begin
                d.vals[q.item] = q.pend;
                d.menu = MS_TOP;
              end
              else if (cmd == CMD_CANCEL)
                d.menu = MS_TOP;
              else if (cmd == CMD_START && q.item == IT_AUTO)
              begin
                d.auto_req = 1'b1;
                d.menu     = MS_AUTO;
              end
              else if (cmd == CMD_START && q.item == IT_CLEAR)
              begin
                d.vals = defaults();
                d.menu = MS_TOP;
              end
            end
          MS_MSG:
            if (cmd_wr && (cmd == CMD_CANCEL || cmd == CMD_SET))
            begin
              d.menu    = MS_TOP;
              d.nosetup = 1'b0;
            end
          MS_AUTO:
            if (AUTO_DONE_I)
            begin
              d.menu = MS_TOP;
              ev[EV_AUTO_DONE] = 1'b1;
            end
          default:
            d.menu = MS_OFF;
        endcase
      end
    end

    // Events win over a clear in the same cycle
    d.irq_st = d.irq_st | ev;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      q         <= '0;
      q.menu    <= MS_OFF;
      q.vals    <= defaults();
      q.irq_mk  <= IRQ_MASK_RST;
    end
    else
      q <= d;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign PREADY_O   = 1'b1;            // Zero wait states
  assign PRDATA_O   = q.prdata;
  assign PSLVERR_O  = q.pslverr && acc;
  assign IRQ_O      = |(q.irq_st & q.irq_mk);

  assign LINK_USB_O      = usb_sel;
  assign VIDEO_DIGITAL_O = digital;
  assign MENU_ACTIVE_O   = (q.menu != MS_OFF);
  // Touches go to the host only with the menu closed
  assign TOUCH_SERIAL_VALID_O = TOUCH_VALID_I && !MENU_ACTIVE_O &&
                                !usb_sel;
  assign TOUCH_USB_VALID_O    = TOUCH_VALID_I && !MENU_ACTIVE_O &&
                                usb_sel;
  assign NOSETUP_MSG_O   = q.nosetup;
  assign AUTO_START_O    = q.auto_req;
  assign SAVE_REQ_O      = q.save_req;
  assign LAMP_GREEN_O    = q.lamp_g;
  assign LAMP_RED_O      = q.lamp_r;

  assign CONTRAST_O    = q.vals[IT_CONTRAST];
  assign BLACK_LEVEL_O = q.vals[IT_BLACK];
  assign HPOS_O        = q.vals[IT_HPOS];
  assign VPOS_O        = q.vals[IT_VPOS];
  assign HSIZE_O       = q.vals[IT_HSIZE];
  assign PHASE_O       = q.vals[IT_PHASE][4:0];
  assign BACKLIGHT_O   = q.vals[IT_LAMP][3:0];
  assign CLICK_EN_O    = (q.vals[IT_CLICK] != 8'h00);
  assign CLICK_LEVEL_O = q.vals[IT_CLICK][2:0];
  assign TEXT_MODE_O   = q.vals[IT_TEXT][0];

endmodule : mmc_top
`default_nettype wire

// ### src/mmc_unused_placeholder_never.sv
/* Empty: no design code here. */

// ### tb/mmc_properties.sv
/* Port checker of mmc_top.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module mmc_properties
  import mmc_pkg::*;
(
  input wire logic       SYS_CLK_I, RESET_N_I, TOUCH_VALID_I,
  input wire logic [1:0] TOUCH_CORNER_I,
  input wire logic       MENU_ACTIVE_O, LINK_USB_O, LAMP_GREEN_O,
  input wire logic       LAMP_RED_O, POWER_ON_I, IMAGE_PRESENT_I,
  input wire logic       BACKLIGHT_BURNT_I, TOUCH_SERIAL_VALID_O,
  input wire logic       TOUCH_USB_VALID_O, TOUCH_LINK_SELECT_SWITCH_I
);
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_open; !MENU_ACTIVE_O ##1 MENU_ACTIVE_O; endsequence
  // Menu opens only right after the last corner
  property p_enter; s_open |-> $past(TOUCH_VALID_I) &&
    $past(TOUCH_CORNER_I) == CORNER_LR; endproperty
  a_enter: assert property (p_enter) else $error("bad open");
  property p_nofwd; MENU_ACTIVE_O |-> !TOUCH_SERIAL_VALID_O &&
    !TOUCH_USB_VALID_O; endproperty
  a_nofwd: assert property (p_nofwd) else $error("leak");
  property p_ser; TOUCH_SERIAL_VALID_O |-> TOUCH_VALID_I && !LINK_USB_O;
  endproperty
  a_ser: assert property (p_ser) else $error("serial");
  property p_usb; TOUCH_VALID_I && !MENU_ACTIVE_O && LINK_USB_O |->
    TOUCH_USB_VALID_O; endproperty
  a_usb: assert property (p_usb) else $error("usb");
  // Lamp follows panel state one cycle later
  property p_dark; !POWER_ON_I |=> !LAMP_GREEN_O && !LAMP_RED_O;
  endproperty
  a_dark: assert property (p_dark) else $error("dark");
  property p_green; POWER_ON_I && !BACKLIGHT_BURNT_I && IMAGE_PRESENT_I
    |=> LAMP_GREEN_O && !LAMP_RED_O; endproperty
  a_green: assert property (p_green) else $error("green");
  property p_orange; POWER_ON_I && !BACKLIGHT_BURNT_I && !IMAGE_PRESENT_I
    |=> LAMP_GREEN_O && LAMP_RED_O; endproperty
  a_orange: assert property (p_orange) else $error("orange");
  // Depth 4 leaves room for the synchroniser stages
  property p_db; $changed(LINK_USB_O) |->
    $past(TOUCH_LINK_SELECT_SWITCH_I, 4) == LINK_USB_O; endproperty
  a_db: assert property (p_db) else $error("bounce");
endmodule : mmc_properties
`default_nettype wire

// ### tb/mmc_host_model.sv
/* Host end of the touch link: counts touches per route.
   Assumes one-cycle strobes on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module mmc_host_model (
  input  wire logic clk_i, ser_i, usb_i,
  output int        ser_cnt_o, usb_cnt_o
);
  // Count what reaches the host on each link
  always @(posedge clk_i)
  begin
    if (ser_i) ser_cnt_o <= ser_cnt_o + 1;
    if (usb_i) usb_cnt_o <= usb_cnt_o + 1;
  end
endmodule : mmc_host_model
`default_nettype wire

// ### tb/mmc_top_tb.sv
/* Bench of mmc_top: APB tasks, touches, lamp, switch, menu.
   Assumes the checker and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
bind mmc_top mmc_properties i_mmc_properties (.SYS_CLK_I, .RESET_N_I,
  .TOUCH_VALID_I, .TOUCH_CORNER_I, .MENU_ACTIVE_O, .LINK_USB_O,
  .LAMP_GREEN_O, .LAMP_RED_O, .POWER_ON_I, .IMAGE_PRESENT_I,
  .BACKLIGHT_BURNT_I, .TOUCH_SERIAL_VALID_O, .TOUCH_USB_VALID_O,
  .TOUCH_LINK_SELECT_SWITCH_I);
module mmc_top_tb
  import mmc_pkg::*;
;
  // -------------------------------------------------------------
  // Stimulus and observed signals
  // -------------------------------------------------------------
  localparam int IDLE = 80; // Short idle limit
  logic clk = 0, rst_n = 0, ps = 0, pe = 0, pw = 0, tv = 0, pwr = 0;
  logic img = 0, sw = 0, rdy, err, irq, usb, men, sv, uv, lg, lr, e;
  logic hd = 0, vd = 0, bb = 0; // Hide, video, burnt-out levels
  logic [7:0] pa = 0, con;
  logic [31:0] pd = 0, pr, rd;
  logic [1:0] tc = 0;
  logic [4:0] ph;
  logic [3:0] bl;
  int error_cnt = 0, check_count = 0, ns, nu;
  always #12.5 clk = ~clk;
  mmc_top #(.GESTURE_CYCLES(50), .IDLE_CYCLES(IDLE), .DEBOUNCE_CYCLES(4),
    .BLINK_CYCLES(8)) i_mmc_top (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
    .PSEL_I(ps), .PENABLE_I(pe), .PWRITE_I(pw), .PADDR_I(pa),
    .PWDATA_I(pd), .PREADY_O(rdy), .PRDATA_O(pr), .PSLVERR_O(err),
    .IRQ_O(irq), .TOUCH_LINK_SELECT_SWITCH_I(sw), .MENU_HIDE_SWITCH_I(hd),
    .VIDEO_INPUT_SELECT_SWITCH_I(vd), .POWER_ON_I(pwr),
    .BACKLIGHT_BURNT_I(bb), .IMAGE_PRESENT_I(img), .TOUCH_VALID_I(tv),
    .TOUCH_CORNER_I(tc), .AUTO_DONE_I(1'b0), .LINK_USB_O(usb),
    .VIDEO_DIGITAL_O(), .TOUCH_SERIAL_VALID_O(sv), .TOUCH_USB_VALID_O(uv),
    .MENU_ACTIVE_O(men), .NOSETUP_MSG_O(), .AUTO_START_O(), .SAVE_REQ_O(),
    .LAMP_GREEN_O(lg), .LAMP_RED_O(lr), .CONTRAST_O(con),
    .BLACK_LEVEL_O(), .HPOS_O(), .VPOS_O(), .HSIZE_O(), .PHASE_O(ph),
    .BACKLIGHT_O(bl), .CLICK_EN_O(), .CLICK_LEVEL_O(), .TEXT_MODE_O());
  mmc_host_model i_mmc_host_model (.clk_i(clk), .ser_i(sv), .usb_i(uv),
    .ser_cnt_o(ns), .usb_cnt_o(nu));
  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    @(posedge clk);
    ps <= 1; pe <= 0; pw <= w; pa <= a; pd <= d;
    @(posedge clk);
    pe <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = pr;
    e = err;
    ps <= 0; pe <= 0;
  endtask : apb
  task automatic cmd(input logic [3:0] it, c, input int k = 1);
    repeat (k) apb(1, REG_CMD, {20'h0, it, 4'h0, c});
  endtask : cmd
  // One-cycle touch pulse
  task automatic tch(input logic [1:0] c);
    @(posedge clk);
    tv <= 1; tc <= c;
    @(posedge clk);
    tv <= 0;
  endtask : tch
  task automatic chk(input string n, input logic [31:0] s, x);
    check_count++;
    if (s !== x)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask : chk
  task automatic results;
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // Hang guard, far beyond the expected run
  initial
  begin
    #500000;
    error_cnt++;
    results();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    apb(0, REG_VAL0, 0); chk("val0", rd, {4{DEF_MID}});
    apb(0, REG_VAL1, 0); chk("val1", rd, {16'h0, DEF_LAMP, DEF_PHASE});
    apb(0, 8'h20, 0); chk("slverr", e, 1);
    chk("dark", {lg, lr}, 0);
    pwr <= 1; img <= 1; repeat (2) @(posedge clk);
    chk("green", {lg, lr}, 2'b10);
    img <= 0; repeat (2) @(posedge clk);
    chk("orange", {lg, lr}, 2'b11);
    tch(CORNER_UL); tch(CORNER_LR); @(posedge clk);
    chk("skip", men, 0);
    tch(CORNER_UL); tch(CORNER_UR); tch(CORNER_LR); @(posedge clk);
    chk("open", men, 1);
    tch(CORNER_NONE); @(posedge clk); chk("ser", ns, 5);
    apb(0, REG_IRQ_STAT, 0); chk("stat", rd, 1 << EV_ENTER);
    chk("masked", irq, 0);
    apb(1, REG_IRQ_MASK, 'h1f); @(posedge clk); chk("irq", irq, 1);
    apb(1, REG_IRQ_STAT, 'h1f); @(posedge clk); chk("clr", irq, 0);
    cmd(IT_LAMP, CMD_OPEN); cmd(IT_LAMP, CMD_DOWN, 9); cmd(IT_LAMP, CMD_SET);
    @(posedge clk); chk("bl", bl, 0);
    cmd(IT_PHASE, CMD_OPEN); cmd(IT_PHASE, CMD_UP, 40);
    cmd(IT_PHASE, CMD_SET); @(posedge clk); chk("ph", ph, MAX_PHASE);
    cmd(IT_CLEAR, CMD_OPEN); cmd(IT_CLEAR, CMD_START); @(posedge clk);
    chk("clear", {ph, bl}, {DEF_PHASE[4:0], DEF_LAMP[3:0]});
    cmd(IT_CONTRAST, CMD_OPEN); cmd(IT_CONTRAST, CMD_UP, 2);
    cmd(0, CMD_CANCEL); @(posedge clk); chk("esc", con, DEF_MID);
    cmd(0, CMD_CANCEL); @(posedge clk); chk("close", men, 0);
    tch(CORNER_UL); tch(CORNER_UR); tch(CORNER_LR);
    cmd(IT_CONTRAST, CMD_OPEN); cmd(IT_CONTRAST, CMD_UP, 3);
    repeat (IDLE + 5) @(posedge clk);
    chk("idle", {men, con}, {1'b0, DEF_MID + 8'h3});
    sw <= 1; repeat (10) @(posedge clk); chk("link", usb, 1);
    tch(CORNER_NONE); @(posedge clk); chk("usb", nu, 1);
    img <= 1; bb <= 1; vd <= 1; repeat (9) @(posedge clk);
    chk("alt", lg ^ lr, 1);
    tch(CORNER_UL); tch(CORNER_UR); tch(CORNER_LR);
    cmd(IT_BLACK, CMD_OPEN); apb(0, REG_STATUS, 0);
    chk("nomsg", rd[7], 1);
    hd <= 1; repeat (9) @(posedge clk); chk("hide", men, 0);
    results();
  end
endmodule : mmc_top_tb
`default_nettype wire
